/* File: tos_pkg.sv */
// constants shared by the one-shot / time-stamp timer block
package tos_pkg;
    // ****************************************************************
    // register indices (avalon word address)
    // ****************************************************************
    localparam logic [6:0] IDX_CTRL   = 7'h00;
    localparam logic [6:0] IDX_SET    = 7'h01;
    localparam logic [6:0] IDX_CLR    = 7'h02;
    localparam logic [6:0] IDX_STATUS = 7'h03;
    localparam logic [6:0] IDX_IFLAG  = 7'h04;
    localparam logic [6:0] IDX_ICLR   = 7'h05;
    localparam logic [6:0] IDX_IEN    = 7'h06;
    localparam logic [6:0] IDX_COUNT  = 7'h07;
    localparam logic [6:0] IDX_CC0    = 7'h08;
    localparam logic [6:0] IDX_PER    = 7'h1a;
    localparam logic [6:0] IDX_CCBUF0 = 7'h30;
    localparam logic [6:0] COMPARE_BUFFER_STEP = 7'h04;
    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int CTRL_EN     = 0;
    localparam int CTRL_ACT_LO = 1;
    localparam int B_SINGLE    = 0;
    localparam int B_LOCK      = 1;
    localparam int B_CMD_LO    = 5;
    localparam int ST_HALT     = 0;
    localparam int ST_SINGLE   = 1;
    localparam int ST_LOCK     = 2;
    localparam int F_OVF       = 0;
    localparam int F_ERR       = 1;
    localparam int F_MC_LO     = 2;
    // ****************************************************************
    // codes, reset values, timing
    // ****************************************************************
    localparam logic [2:0]  ACT_STAMP   = 3'h5;
    localparam logic [2:0]  CMD_RETRIG  = 3'h1;
    localparam logic [2:0]  CMD_UPDATE  = 3'h3;
    localparam logic [31:0] PER_RESET   = 32'h0fffffff;
    localparam logic [31:0] COMPARE_BUFFER_RESET = 32'h00000000;
    localparam logic [31:0] COUNT_MAX   = 32'hffffffff;
    localparam int          SYNC_CYCLES = 2;
endpackage

/* File: tos_sync_if.sv */
// write-synchronizer handshake between the timer and its synchronizer
`timescale 1ns/10ps
interface tos_sync_if;
    logic req;   // held by the timer until done
    logic done;  // one-cycle pulse, write may take effect
    modport src (output req, input done);
    modport dst (input req, output done);
endinterface

/* File: tos_wr_sync.sv */
// synchronizer delay for period and compare buffer writes
`timescale 1ns/10ps
module tos_wr_sync #(
    parameter int STAGES = tos_pkg::SYNC_CYCLES
) (
    // clock and reset
    input  wire logic   clk,
    input  wire logic   rst_n,
    // handshake
    tos_sync_if.dst     sync
);
    logic [3:0] cnt_q;
    logic       busy_q;
    logic       done_q;

    // a new write starts only once the previous done pulse has passed
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q  <= 4'h0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else if (busy_q) begin
            cnt_q  <= cnt_q + 4'h1;
            done_q <= (cnt_q == 4'(STAGES - 1));
            busy_q <= (cnt_q != 4'(STAGES - 1));
        end else begin
            cnt_q  <= 4'h1;
            done_q <= 1'b0;
            busy_q <= sync.req && !done_q;
        end
    end

    assign sync.done = done_q;
endmodule // tos_wr_sync

/* File: tos_timer.sv */
// 32-bit timer with one-shot, time-stamp capture and buffered updates
// Operation
// - capture while channel flag set is dropped, old value kept, fault flag set
// - single-run counter halts at its first overflow
// - on halt, halted flag set and waveform outputs forced low
// - write one to set bit enables single-run, clear bit disables it
// - halted counter restarts on retrigger command, retrigger or start event
// - halted flag clears automatically when counting resumes
// - time-stamp capture works only while event action selects stamp
// - capture event copies the counter into that channel's capture value
// - capture on an overflow stores the counter maximum instead
// - channel flag set whenever a valid captured value is held
// - period takes the shadow value on every update condition
// - valid compare buffer moves into compare on update while unlocked, command 0x3 too
// - one 32-bit compare buffer per channel, four word addresses apart
`timescale 1ns/10ps
module tos_timer #(
    parameter int CH = 2
) (
    // clock and reset
    input  wire logic          clk,
    input  wire logic          reset_n,
    // avalon-mm slave
    input  wire logic [6:0]    address,
    input  wire logic          read,
    input  wire logic          write,
    input  wire logic [31:0]   writedata,
    output logic [31:0]        readdata,
    output logic               waitrequest,
    // event system
    input  wire logic [CH-1:0] capture_evt,
    input  wire logic          retrigger_evt,
    input  wire logic          start_evt,
    // pins and interrupt
    output logic [CH-1:0]      wave_out,
    output logic               irq
);
    // ****************************************************************
    // reset release
    // ****************************************************************
    logic [1:0] rst_q;
    logic       rst_n;

    // the release is synchronized, the assertion stays asynchronous
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_q <= 2'b00;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    assign rst_n = rst_q[1];

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // ****************************************************************
    // state
    // ****************************************************************
    logic [31:0]        count_q, per_q, cycle_length_shadow_q;
    logic [31:0]        cc_q  [CH];
    logic [31:0]        ccb_q [CH];
    logic [CH-1:0]      ccb_vld_q, mc_q, cap_ok, cap_bad;
    logic               en_q, single_q, lock_q, halt_q, err_q, ovf_fl_q;
    logic [2:0]         act_q;
    logic [CH+1:0]      ien_q, flags;
    logic               rd_ack_q;
    logic [31:0]        rdata_q;
    logic [CH-1:0]      wave_q;

    // ****************************************************************
    // bus decode
    // ****************************************************************
    tos_sync_if sync ();

    logic        is_per, sync_sel, wr_acc, rd_acc;
    logic [CH-1:0] is_ccb;
    logic [2:0]  cmd;

    // per-channel compare buffer decode at base plus step
    for (genvar i = 0; i < CH; i++) begin : g_dec
        assign is_ccb[i] = address == tos_pkg::IDX_CCBUF0
                           + 7'(i) * tos_pkg::COMPARE_BUFFER_STEP;
    end

    assign is_per      = address == tos_pkg::IDX_PER;
    assign sync_sel    = is_per || (|is_ccb);
    assign sync.req    = write && sync_sel;
    // buffered writes stall until the synchronizer is through
    assign waitrequest = (read && !rd_ack_q)
                         || (sync.req && !sync.done);
    assign wr_acc      = write && !waitrequest;
    assign rd_acc      = read && rd_ack_q;
    assign cmd         = (wr_acc && address == tos_pkg::IDX_SET)
                         ? writedata[tos_pkg::B_CMD_LO +: 3] : 3'h0;

    tos_wr_sync #(
        .STAGES (tos_pkg::SYNC_CYCLES)
    ) u_sync (
        .clk    (clk),
        .rst_n  (rst_n),
        .sync   (sync)
    );

    // ****************************************************************
    // counter core
    // ****************************************************************
    logic running, ovf, restart, upd, halt_d, stamp;

    assign running = en_q && !halt_q;
    assign ovf     = running && count_q == per_q;
    assign restart = start_evt || retrigger_evt
                     || cmd == tos_pkg::CMD_RETRIG;
    assign upd     = ovf || cmd == tos_pkg::CMD_UPDATE;
    assign stamp   = act_q == tos_pkg::ACT_STAMP;
    // a restart in the same cycle as the halt wins, so no pulse is lost
    assign halt_d  = restart ? 1'b0
                   : (ovf && single_q) ? 1'b1 : halt_q;

    // counting wraps at the period
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= 32'h0;
        end else if (restart) begin
            count_q <= 32'h0;
        end else if (running) begin
            count_q <= ovf ? 32'h0 : count_q + 32'h1;
        end
    end

    // halted state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            halt_q <= 1'b0;
        end else begin
            halt_q <= halt_d;
        end
    end

    // period and its shadow; shadow written only after synchronization
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cycle_length_shadow_q <= tos_pkg::PER_RESET;
            per_q    <= tos_pkg::PER_RESET;
        end else begin
            if (wr_acc && is_per) begin
                cycle_length_shadow_q <= writedata;
            end
            if (upd) begin
                per_q <= cycle_length_shadow_q;
            end
        end
    end

    // ****************************************************************
    // control registers
    // ****************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            en_q     <= 1'b0;
            act_q    <= 3'h0;
            single_q <= 1'b0;
            lock_q   <= 1'b0;
            ien_q    <= '0;
        end else if (wr_acc) begin
            if (address == tos_pkg::IDX_CTRL) begin
                en_q  <= writedata[tos_pkg::CTRL_EN];
                act_q <= writedata[tos_pkg::CTRL_ACT_LO +: 3];
            end
            // zeros leave the settings alone
            if (address == tos_pkg::IDX_SET) begin
                if (writedata[tos_pkg::B_SINGLE]) single_q <= 1'b1;
                if (writedata[tos_pkg::B_LOCK])   lock_q   <= 1'b1;
            end
            if (address == tos_pkg::IDX_CLR) begin
                if (writedata[tos_pkg::B_SINGLE]) single_q <= 1'b0;
                if (writedata[tos_pkg::B_LOCK])   lock_q   <= 1'b0;
            end
            if (address == tos_pkg::IDX_IEN) begin
                ien_q <= writedata[CH+1:0];
            end
        end
    end

    // ****************************************************************
    // channels: capture, buffer, flags
    // ****************************************************************
    logic [CH-1:0] cc_rd, clr_mc;
    logic          clr_err;

    assign clr_err = (wr_acc && address == tos_pkg::IDX_ICLR
                      && writedata[tos_pkg::F_ERR]) || (|cc_rd);

    for (genvar i = 0; i < CH; i++) begin : g_ch
        assign cc_rd[i]   = rd_acc && address == tos_pkg::IDX_CC0 + 7'(i);
        assign clr_mc[i]  = cc_rd[i] || (wr_acc
                            && address == tos_pkg::IDX_ICLR
                            && writedata[tos_pkg::F_MC_LO + i]);
        assign cap_ok[i]  = stamp && capture_evt[i] && !mc_q[i];
        assign cap_bad[i] = stamp && capture_evt[i] && mc_q[i];

        // capture beats buffered update when both land together
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                cc_q[i] <= 32'h0;
            end else if (cap_ok[i]) begin
                cc_q[i] <= ovf ? tos_pkg::COUNT_MAX
                               : count_q;
            end else if (upd && ccb_vld_q[i] && !lock_q) begin
                cc_q[i] <= ccb_q[i];
            end
        end

        // buffer and its valid flag
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                ccb_q[i]     <= tos_pkg::COMPARE_BUFFER_RESET;
                ccb_vld_q[i] <= 1'b0;
            end else if (wr_acc && is_ccb[i]) begin
                ccb_q[i]     <= writedata;
                ccb_vld_q[i] <= 1'b1;
            end else if (upd && !lock_q) begin
                ccb_vld_q[i] <= 1'b0;
            end
        end

        // capture flag: a new capture wins over a clear
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                mc_q[i] <= 1'b0;
            end else if (cap_ok[i]) begin
                mc_q[i] <= 1'b1;
            end else if (clr_mc[i]) begin
                mc_q[i] <= 1'b0;
            end
        end

        // compare waveform, zero while halted
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                wave_q[i] <= 1'b0;
            end else begin
                wave_q[i] <= !halt_d && en_q && count_q < cc_q[i];
            end
        end
    end

    // fault and overflow flags, set wins over clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            err_q    <= 1'b0;
            ovf_fl_q <= 1'b0;
        end else begin
            if (|cap_bad) begin
                err_q <= 1'b1;
            end else if (clr_err) begin
                err_q <= 1'b0;
            end
            if (ovf) begin
                ovf_fl_q <= 1'b1;
            end else if (wr_acc && address == tos_pkg::IDX_ICLR
                         && writedata[tos_pkg::F_OVF]) begin
                ovf_fl_q <= 1'b0;
            end
        end
    end

    assign flags    = {mc_q, err_q, ovf_fl_q};
    assign wave_out = wave_q;
    assign irq      = |(flags & ien_q);

    // ****************************************************************
    // read path: one wait cycle, data from a flop
    // ****************************************************************
    logic [31:0] rmux;

    always_comb begin
        rmux = 32'h0;
        unique case (address)
            tos_pkg::IDX_CTRL:   rmux = {28'h0, act_q, en_q};
            tos_pkg::IDX_STATUS: rmux = {29'h0, lock_q, single_q, halt_q};
            tos_pkg::IDX_IFLAG:  rmux = 32'(flags);
            tos_pkg::IDX_IEN:    rmux = 32'(ien_q);
            tos_pkg::IDX_COUNT:  rmux = count_q;
            tos_pkg::IDX_PER:    rmux = per_q;
            default: begin
                for (int i = 0; i < CH; i++) begin
                    if (address == tos_pkg::IDX_CC0 + 7'(i)) rmux = cc_q[i];
                    if (is_ccb[i]) rmux = ccb_q[i];
                end
            end
        endcase
    end

    // the data flop loads in the wait cycle and stands at acceptance
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_ack_q <= 1'b0;
            rdata_q  <= 32'h0;
        end else begin
            rd_ack_q <= read && !rd_ack_q;
            if (read && !rd_ack_q) begin
                rdata_q <= rmux;
            end
        end
    end
    assign readdata = rdata_q;

    // ****************************************************************
    // checks
    // ****************************************************************
    fault_keep_a: assert property (
        cap_bad[0] |=> err_q && $stable(cc_q[0]))
        else $error("capture overwrote a held value");
    run_halt_a: assert property (
        ovf && single_q && !restart |=> halt_q && count_q == 32'h0)
        else $error("single-run counter did not halt");
    wave_zero_a: assert property (
        halt_q |-> wave_out == '0)
        else $error("waveform high while halted");
    single_set_a: assert property (
        wr_acc && address == tos_pkg::IDX_SET && writedata[0] |=> single_q)
        else $error("single-run not enabled");
    resume_a: assert property (
        halt_q && start_evt |=> !halt_q && count_q == 32'h0)
        else $error("halted counter did not restart");
    stamp_only_a: assert property (
        !stamp |=> !$rose(mc_q[0]))
        else $error("capture outside stamp mode");
    stamp_copy_a: assert property (
        cap_ok[0] && !ovf |=> cc_q[0] == $past(count_q) && mc_q[0])
        else $error("timestamp not captured");
    stamp_max_a: assert property (
        cap_ok[0] && ovf |=> cc_q[0] == tos_pkg::COUNT_MAX)
        else $error("overflow did not store max");
    per_update_a: assert property (
        upd |=> per_q == $past(cycle_length_shadow_q))
        else $error("period not updated");
    buf_move_a: assert property (
        upd && ccb_vld_q[1] && !lock_q && !cap_ok[1] && !(wr_acc && is_ccb[1])
        |=> cc_q[1] == $past(ccb_q[1]) && !ccb_vld_q[1])
        else $error("compare buffer not moved");
    flag_clear_a: assert property (
        cc_rd[0] && !cap_ok[0] |=> !mc_q[0] && !err_q || $past(|cap_bad))
        else $error("capture flag not cleared by read");
    sync_wait_a: assert property (
        $rose(sync.req) |-> waitrequest [*2])
        else $error("buffered write not held for sync");
endmodule // tos_timer

/* File: tos_evt_src.sv */
// event system model driving capture, retrigger and start pulses
`timescale 1ns/10ps
module tos_evt_src #(
    parameter int CH = 2
) (
    // clock
    input  wire logic     clk,
    // events towards the timer
    output logic [CH-1:0] capture_evt,
    output logic          retrigger_evt,
    output logic          start_evt
);
    // idle events are low from time zero
    initial begin
        capture_evt   = {CH{1'h0}};
        retrigger_evt = 1'h0;
        start_evt     = 1'h0;
    end
    // one single-cycle capture pulse; entering at an edge keeps pulses apart
    task automatic cap(input int ch);
        @(posedge clk);
        capture_evt[ch] <= 1'h1;
        @(posedge clk);
        capture_evt     <= {CH{1'h0}};
    endtask
    // restart pulse, then a capture taken k edges after the restart edge
    task automatic restart_cap(input int kind, input int ch, input int k);
        @(posedge clk);
        if (kind == 0) begin
            start_evt <= 1'h1;
        end else begin
            retrigger_evt <= 1'h1;
        end
        @(posedge clk);
        start_evt     <= 1'h0;
        retrigger_evt <= 1'h0;
        repeat (k - 1) @(posedge clk);
        capture_evt[ch] <= 1'h1;
        @(posedge clk);
        capture_evt     <= {CH{1'h0}};
    endtask
endmodule // tos_evt_src

/* File: timer_oneshot_timestamp_capture_tb.sv */
// self-checking bench for the one-shot and time-stamp timer
`timescale 1ns/10ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module timer_oneshot_timestamp_capture_tb;
    // ****************
    // signals and model state
    // ****************
    logic        clk;
    logic        reset_n;
    logic [6:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [31:0] readdata;
    logic        waitrequest;
    logic [1:0]  capture_evt;
    logic        retrigger_evt;
    logic        start_evt;
    logic [1:0]  wave_out;
    logic        irq;
    logic [31:0] rd;
    logic [31:0] b1;
    int          errors;
    int          checks;
    int          seed;
    int          waits;
    int          k;
    int          m_single;
    int          m_cc [2];
    int          cap_q [$];
    // ****************
    // design and event partner
    // ****************
    tos_timer #(.CH(2)) tos_timer_inst (
        .clk(clk), .reset_n(reset_n), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .capture_evt(capture_evt), .retrigger_evt(retrigger_evt), .start_evt(start_evt),
        .wave_out(wave_out), .irq(irq));
    tos_evt_src #(.CH(2)) tos_evt_src_inst (
        .clk(clk), .capture_evt(capture_evt), .retrigger_evt(retrigger_evt),
        .start_evt(start_evt));
    // 10 MHz clock
    initial begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end
    // ****************
    // tasks
    // ****************
    // avalon transfer; request held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic wr, input logic [6:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        address   <= a;
        write     <= wr;
        read      <= !wr;
        writedata <= d;
        @(posedge clk);
        while (waitrequest !== 1'h0) begin
            n++;
            @(posedge clk);
        end
        rd    = readdata;
        waits = n;
        read  <= 1'h0;
        write <= 1'h0;
    endtask
    task automatic rdchk(input logic [6:0] a, input logic [31:0] e);
        bus(1'h0, a, 32'h0);
        `CHK(rd, e)
    endtask
    // buffered values move on an update command or on an overflow
    task automatic upd();
        bus(1'h1, tos_pkg::IDX_SET, 32'(tos_pkg::CMD_UPDATE) << tos_pkg::B_CMD_LO);
    endtask
    // bounded poll of the halted flag
    task automatic wait_halt();
        for (int n = 0; n < 100; n++) begin
            bus(1'h0, tos_pkg::IDX_STATUS, 32'h0);
            if (rd[tos_pkg::ST_HALT] === 1'h1) break;
        end
        `CHK(rd[tos_pkg::ST_HALT], 1'h1)
    endtask
    task automatic finish_test();
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // watchdog: the whole run needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        finish_test();
    end
    // ****************
    // main sequence
    // ****************
    initial begin
        logic [6:0] ta [5];
        int         td [5];
        seed = 21463;
        errors = 0;
        checks = 0;
        reset_n = 1'h0;
        address = 7'h00;
        read = 1'h0;
        write = 1'h0;
        writedata = 32'h0;
        ta = '{tos_pkg::IDX_SET, tos_pkg::IDX_SET, tos_pkg::IDX_CLR, tos_pkg::IDX_CLR,
               tos_pkg::IDX_SET};
        td = '{0, 1, 0, 1, 1};
        repeat (10) @(posedge clk);
        reset_n <= 1'h1;
        repeat (3) @(posedge clk);
        rdchk(tos_pkg::IDX_PER, tos_pkg::PER_RESET);
        rdchk(tos_pkg::IDX_CCBUF0, tos_pkg::COMPARE_BUFFER_RESET);
        rdchk(7'h7f, 32'h0);
        $display("test reset values done");
        // period below the counter maximum keeps stamping meaningful
        bus(1'h1, tos_pkg::IDX_PER, 32'h40);
        `CHK(waits, tos_pkg::SYNC_CYCLES)
        rdchk(tos_pkg::IDX_PER, tos_pkg::PER_RESET);
        b1 = (32'($random(seed)) & 32'h1f) | 32'h20;
        bus(1'h1, tos_pkg::IDX_CCBUF0, 32'h10);
        bus(1'h1, tos_pkg::IDX_CCBUF0 + tos_pkg::COMPARE_BUFFER_STEP, b1);
        `CHK(waits, tos_pkg::SYNC_CYCLES)
        rdchk(tos_pkg::IDX_CCBUF0 + tos_pkg::COMPARE_BUFFER_STEP, b1);
        upd();
        m_cc = '{32'h10, b1};
        rdchk(tos_pkg::IDX_PER, 32'h40);
        rdchk(tos_pkg::IDX_CC0, m_cc[0]);
        rdchk(tos_pkg::IDX_CC0 + 7'h1, m_cc[1]);
        bus(1'h1, tos_pkg::IDX_SET, 32'h1 << tos_pkg::B_LOCK);
        bus(1'h1, tos_pkg::IDX_CCBUF0, 32'h18);
        upd();
        rdchk(tos_pkg::IDX_CC0, m_cc[0]);
        bus(1'h1, tos_pkg::IDX_CLR, 32'h1 << tos_pkg::B_LOCK);
        upd();
        m_cc[0] = 32'h18;
        rdchk(tos_pkg::IDX_CC0, m_cc[0]);
        $display("test buffered update done");
        m_single = 0;
        for (int i = 0; i < 5; i++) begin
            bus(1'h1, ta[i], 32'(td[i]));
            if (td[i] == 1) m_single = (ta[i] == tos_pkg::IDX_SET);
            bus(1'h0, tos_pkg::IDX_STATUS, 32'h0);
            `CHK(rd[tos_pkg::ST_SINGLE], 1'(m_single))
        end
        $display("test single-run bits done");
        bus(1'h1, tos_pkg::IDX_IEN, 32'h1);
        bus(1'h1, tos_pkg::IDX_CTRL, 32'h1);
        // count starts at zero, below both compare values, so both outputs go high
        repeat (2) @(negedge clk);
        `CHK(wave_out, 2'h3)
        wait_halt();
        `CHK(wave_out, 2'h0)
        tos_evt_src_inst.cap(0);
        bus(1'h0, tos_pkg::IDX_IFLAG, 32'h0);
        `CHK(rd[tos_pkg::F_MC_LO], 1'h0)
        `CHK(rd[tos_pkg::F_OVF], 1'h1)
        bus(1'h1, tos_pkg::IDX_IEN, 32'h0);
        @(negedge clk);
        `CHK(irq, 1'h0)
        bus(1'h1, tos_pkg::IDX_IEN, 32'h1);
        @(negedge clk);
        `CHK(irq, 1'h1)
        bus(1'h1, tos_pkg::IDX_ICLR, 32'hf);
        @(negedge clk);
        `CHK(irq, 1'h0)
        rdchk(tos_pkg::IDX_IFLAG, 32'h0);
        $display("test halt and interrupt done");
        // stamp mode: start and retrigger events each with a capture and a refused second capture, then a retrigger command
        bus(1'h1, tos_pkg::IDX_CTRL, {28'h0, tos_pkg::ACT_STAMP, 1'h1});
        for (int kind = 0; kind < 3; kind++) begin
            if (kind == 2) begin
                bus(1'h1, tos_pkg::IDX_SET, 32'(tos_pkg::CMD_RETRIG) << tos_pkg::B_CMD_LO);
                bus(1'h0, tos_pkg::IDX_STATUS, 32'h0);
                `CHK(rd[tos_pkg::ST_HALT], 1'h0)
            end else begin
                k = 2 + ($random(seed) & 7);
                cap_q.push_back(k - 1);
                tos_evt_src_inst.restart_cap(kind, kind, k);
                tos_evt_src_inst.cap(kind);
                bus(1'h0, tos_pkg::IDX_STATUS, 32'h0);
                `CHK(rd[tos_pkg::ST_HALT], 1'h0)
                bus(1'h0, tos_pkg::IDX_IFLAG, 32'h0);
                `CHK(rd & 32'he, (32'h1 << (tos_pkg::F_MC_LO + kind)) | 32'h2)
                m_cc[kind] = cap_q.pop_front();
                rdchk(tos_pkg::IDX_CC0 + 7'(kind), m_cc[kind]);
                bus(1'h0, tos_pkg::IDX_IFLAG, 32'h0);
                `CHK(rd & 32'he, 32'h0)
            end
            wait_halt();
            `CHK(wave_out, 2'h0)
        end
        // capture landing on the overflow cycle (count equals period 0x40)
        tos_evt_src_inst.restart_cap(0, 1, 32'h41);
        rdchk(tos_pkg::IDX_CC0 + 7'h1, tos_pkg::COUNT_MAX);
        $display("test stamp and restart done");
        finish_test();
    end
endmodule // timer_oneshot_timestamp_capture_tb
